// ### src/lhp_device.sv
`include "lhp_consts.svh"
// Summary of operation
// - serial write: float 8 cycles, then low
// - serial read: float only during command byte
// - output edge chosen by edge select
// - ready low means host adds wait states
// - acknowledge low: read valid, write accepted
// - one open-drain interrupt from four sources
// - hardware mode: three-level loopback decode per channel
// - non-multiplexed: shared pins are data bus
// - multiplexed: address then data on pins
// - serial mode: host grounds the data pins
// - serial input sampled on rising edges
// - address from low five bits, latch falling
// - write data captured on write strobe rise
// - acknowledge style read data follows data strobe
module lhp_device (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  lhp_if.dev               lnk,
  input  wire logic [3:0]  irq_src,
  input  wire logic [7:0]  rd_data,
  input  wire logic        rd_valid,
  output logic      [4:0]  reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             wr_req,
  output logic             rd_req,
  output logic      [15:0] loop_mode
);
  lhp_pkg::lhp_dev_t s;
  lhp_pkg::lhp_dev_t n;
  logic       p_cs_n;
  logic       p_a;
  logic       p_b;
  logic       p_c;
  logic       p_mux;
  logic [1:0] p_mode;
  logic [4:0] p_addr;
  logic [7:0] p_bus;
  logic [7:0] p_mid;
  logic       p_edge;
  logic       armed;
  logic       a_rise;
  logic       a_fall;
  logic       b_rise;
  logic       b_fall;
  logic       c_rise;
  logic       c_fall;
  logic       got;
  logic       launch;
  // =====================================
  // pin synchronisers
  lhp_sync #(.W(`LHP_DSYNC_W)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({lnk.cs_n, lnk.pin_shift_clk, lnk.pin_rd_dir, lnk.pin_wr_strobe, lnk.mux_sel,
               lnk.mode, lnk.addr, lnk.data_bus, lnk.loop_select_mid, lnk.edge_select}),
    .q       ({p_cs_n, p_a, p_b, p_c, p_mux, p_mode, p_addr, p_bus, p_mid, p_edge})
  );
  // =====================================
  // edge detection, held off until synchronisers settle
  assign armed  = (s.arm == `LHP_ARM_DONE);
  assign a_rise = armed & p_a & ~s.prev[2];
  assign a_fall = armed & ~p_a & s.prev[2];
  assign b_rise = armed & p_b & ~s.prev[1];
  assign b_fall = armed & ~p_b & s.prev[1];
  assign c_rise = armed & p_c & ~s.prev[0];
  assign c_fall = armed & ~p_c & s.prev[0];
  assign got    = s.rd_pend & rd_valid;
  assign launch = p_edge ? a_fall : a_rise;
  // =====================================
  // next state
  always_comb begin
    n          = s;
    n.wr_req   = 1'b0;
    n.rd_req   = 1'b0;
    n.prev     = {p_a, p_b, p_c};
    n.int_oe_n = ~|irq_src;
    if (!armed) begin
      n.arm = s.arm + 2'h1;
    end
    if (got) begin
      n.rbuf    = rd_data;
      n.rd_pend = 1'b0;
    end
    if (p_mode != `LHP_MODE_HW) begin
      n.loop_mode = 16'h0000;
    end
    unique case (p_mode)
      `LHP_MODE_HW: begin
        n.sout_oe_n = 1'b1;
        n.bus_oe_n  = 1'b1;
        n.cnt       = 5'h00;
        for (int i = 0; i < `LHP_NCH; i++) begin
          if (p_mid[i]) begin
            n.loop_mode[2*i+:2] = `LHP_LOOP_NONE;
          end else if (p_bus[i]) begin
            n.loop_mode[2*i+:2] = `LHP_LOOP_ANALOG;
          end else begin
            n.loop_mode[2*i+:2] = `LHP_LOOP_REMOTE;
          end
        end
      end
      `LHP_MODE_SER: begin
        n.bus_oe_n = 1'b1;
        if (p_cs_n) begin
          n.cnt       = 5'h00;
          n.sout      = 1'b1;
          n.sout_oe_n = 1'b1;
          n.rd_pend   = 1'b0;
        end else begin
          if (a_rise && s.cnt != `LHP_CNT_END) begin
            n.shin = {s.shin[6:0], p_c};
            n.cnt  = s.cnt + 5'h01;
            if (n.cnt == `LHP_CNT_CMD) begin
              n.cmd       = n.shin;
              n.reg_addr  = n.shin[4:0];
              n.sout_oe_n = 1'b0;
              n.sout      = 1'b0;
              if (n.shin[`LHP_CMD_RD]) begin
                n.rd_req  = 1'b1;
                n.rd_pend = 1'b1;
              end
            end else if (n.cnt == `LHP_CNT_END && !s.cmd[`LHP_CMD_RD]) begin
              n.wr_req    = 1'b1;
              n.reg_wdata = n.shin;
            end
          end
          if (n.cmd[`LHP_CMD_RD] && !n.sout_oe_n && n.cnt != `LHP_CNT_END && (launch || (got && !p_edge))) begin
            n.sout = n.rbuf[~n.cnt[2:0]];
          end
        end
      end
      `LHP_MODE_STB: begin
        n.sout_oe_n = 1'b0;
        if (p_mux && a_fall) begin
          n.alat = p_bus[4:0];
        end
        if (b_fall) begin
          n.rd_req   = 1'b1;
          n.reg_addr = p_mux ? s.alat : p_addr;
          n.rd_pend  = 1'b1;
          n.sout     = 1'b0;
        end
        if (got) begin
          n.bus_o    = rd_data;
          n.bus_oe_n = 1'b0;
          n.sout     = 1'b1;
        end
        if (b_rise) begin
          n.bus_oe_n = 1'b1;
          n.rd_pend  = 1'b0;
          n.sout     = 1'b1;
        end
        if (c_rise) begin
          n.wr_req    = 1'b1;
          n.reg_addr  = p_mux ? s.alat : p_addr;
          n.reg_wdata = p_bus;
        end
      end
      `LHP_MODE_ACK: begin
        n.sout_oe_n = 1'b0;
        if (p_mux && a_fall) begin
          n.alat = p_bus[4:0];
        end
        if (c_fall) begin
          if (!p_mux) begin
            n.alat = p_addr;
          end
          if (p_b) begin
            n.rd_req   = 1'b1;
            n.reg_addr = p_mux ? s.alat : p_addr;
            n.rd_pend  = 1'b1;
          end else begin
            n.sout = 1'b0;
          end
        end
        if (got) begin
          n.bus_o    = rd_data;
          n.bus_oe_n = 1'b0;
          n.sout     = 1'b0;
        end
        if (c_rise) begin
          if (!p_b) begin
            n.wr_req    = 1'b1;
            n.reg_addr  = s.alat;
            n.reg_wdata = p_bus;
          end
          n.bus_oe_n = 1'b1;
          n.rd_pend  = 1'b0;
          n.sout     = 1'b1;
        end
      end
    endcase
  end
  // =====================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s           <= '0;
      s.prev      <= 3'h7;
      s.sout      <= 1'b1;
      s.sout_oe_n <= 1'b1;
      s.bus_oe_n  <= 1'b1;
      s.int_oe_n  <= 1'b1;
    end else begin
      s <= n;
    end
  end
  // =====================================
  // outputs
  assign lnk.dev_bus_o    = s.bus_o;
  assign lnk.dev_bus_oe_n = s.bus_oe_n;
  assign lnk.dev_out      = s.sout;
  assign lnk.dev_out_oe_n = s.sout_oe_n;
  assign lnk.dev_int_oe_n = s.int_oe_n;
  assign reg_addr         = s.reg_addr;
  assign reg_wdata        = s.reg_wdata;
  assign wr_req           = s.wr_req;
  assign rd_req           = s.rd_req;
  assign loop_mode        = s.loop_mode;
endmodule // lhp_device

// ### src/lhp_consts.svh
`ifndef LHP_CONSTS_SVH
`define LHP_CONSTS_SVH
// =====================================
// host port modes
`define LHP_MODE_HW     2'h0
`define LHP_MODE_SER    2'h1
`define LHP_MODE_STB    2'h2
`define LHP_MODE_ACK    2'h3
// =====================================
// serial frame
`define LHP_CNT_CMD     5'h08
`define LHP_CNT_END     5'h10
`define LHP_CMD_RD      7
// =====================================
// loopback decode per channel
`define LHP_NCH         8
`define LHP_LOOP_NONE   2'h0
`define LHP_LOOP_REMOTE 2'h1
`define LHP_LOOP_ANALOG 2'h2
// =====================================
// timing and widths
`define LHP_ARM_DONE    2'h3
`define LHP_HALF_DEF    16
`define LHP_HALF_MIN    4
`define LHP_HALF_MAX    255
`define LHP_DSYNC_W     29
`define LHP_HSYNC_W     10
`endif

// ### src/lhp_pkg.sv
package lhp_pkg;
  // =====================================
  // host sequencer states
  typedef enum logic [5:0] {
    H_IDLE    = 6'h01,
    H_SHIFT   = 6'h02,
    H_ADDR    = 6'h04,
    H_STROBE  = 6'h08,
    H_WAIT    = 6'h10,
    H_RELEASE = 6'h20
  } lhp_hstate_t;
  // =====================================
  // device end state
  typedef struct packed {
    logic [1:0]  arm;
    logic [2:0]  prev;
    logic [4:0]  cnt;
    logic [7:0]  cmd;
    logic [7:0]  shin;
    logic [7:0]  rbuf;
    logic        rd_pend;
    logic [4:0]  alat;
    logic        sout;
    logic        sout_oe_n;
    logic [7:0]  bus_o;
    logic        bus_oe_n;
    logic        int_oe_n;
    logic [4:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        wr_req;
    logic        rd_req;
    logic [15:0] loop_mode;
  } lhp_dev_t;
  // =====================================
  // host end state
  typedef struct packed {
    lhp_hstate_t st;
    logic        ph;
    logic [7:0]  tcnt;
    logic [4:0]  bcnt;
    logic [15:0] sreg;
    logic [7:0]  rsh;
    logic        rd;
    logic        cs_n;
    logic        pa;
    logic        pb;
    logic        pc;
    logic [4:0]  addr_o;
    logic [7:0]  bus_o;
    logic        bus_oe_n;
    logic [1:0]  mode_o;
    logic        mux_o;
    logic        edge_o;
    logic [7:0]  mid_o;
    logic        cmd_ready;
    logic        rsp_valid;
    logic [7:0]  rsp_rdata;
  } lhp_host_t;
endpackage

// ### src/lhp_if.sv
interface lhp_if;
  logic       cs_n;
  logic       pin_shift_clk;
  logic       pin_rd_dir;
  logic       pin_wr_strobe;
  logic       mux_sel;
  logic       edge_select;
  logic [1:0] mode;
  logic [4:0] addr;
  logic [7:0] host_bus_o;
  logic       host_bus_oe_n;
  logic [7:0] loop_select_mid;
  logic [7:0] dev_bus_o;
  logic       dev_bus_oe_n;
  logic       dev_out;
  logic       dev_out_oe_n;
  logic       dev_int_oe_n;
  logic [7:0] data_bus;
  logic       pin_out_ready;
  logic       int_n;
  // =====================================
  // wire resolution: pull-up on out pin and interrupt, pull-down on bus
  assign data_bus      = !dev_bus_oe_n ? dev_bus_o : (!host_bus_oe_n ? host_bus_o : 8'h00);
  assign pin_out_ready = dev_out_oe_n ? 1'b1 : dev_out;
  assign int_n         = dev_int_oe_n;
  modport dev (
    input  cs_n, pin_shift_clk, pin_rd_dir, pin_wr_strobe, mux_sel, edge_select, mode, addr,
    input  loop_select_mid, data_bus,
    output dev_bus_o, dev_bus_oe_n, dev_out, dev_out_oe_n, dev_int_oe_n
  );
  modport host (
    output cs_n, pin_shift_clk, pin_rd_dir, pin_wr_strobe, mux_sel, edge_select, mode, addr,
    output host_bus_o, host_bus_oe_n, loop_select_mid,
    input  data_bus, pin_out_ready, int_n
  );
endinterface

// ### src/lhp_sync.sv
module lhp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lhp_sync_t;
  lhp_sync_t s;
  lhp_sync_t next_s;
  if (W < 1) begin : g_chk
    $error("lhp_sync width must be positive");
  end
  always_comb begin
    next_s    = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) s <= '0;
    else s <= next_s;
  end
  assign q = s.s2;
endmodule // lhp_sync

// ### src/lhp_host.sv
`include "lhp_consts.svh"
module lhp_host #(
  parameter int HALF = `LHP_HALF_DEF
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  lhp_if.host             lnk,
  input  wire logic [1:0] mode_sel,
  input  wire logic       mux_sel,
  input  wire logic       edge_sel,
  input  wire logic [7:0] loop_strap,
  input  wire logic [7:0] loop_mid_strap,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_write,
  input  wire logic [4:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic      [7:0] rsp_rdata,
  output logic            irq_n
);
  localparam logic [7:0] HALF_M1 = 8'(HALF - 1);
  lhp_pkg::lhp_host_t s;
  lhp_pkg::lhp_host_t n;
  logic       out_q;
  logic [7:0] bus_q;
  logic       tdone;
  if (HALF < `LHP_HALF_MIN || HALF > `LHP_HALF_MAX) begin : g_chk
    $error("lhp_host HALF out of range");
  end
  // =====================================
  // pin synchronisers
  lhp_sync #(.W(`LHP_HSYNC_W)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({lnk.pin_out_ready, lnk.int_n, lnk.data_bus}),
    .q       ({out_q, irq_n, bus_q})
  );
  assign tdone = (s.tcnt == HALF_M1);
  // =====================================
  // sequencer
  always_comb begin
    n           = s;
    n.rsp_valid = 1'b0;
    n.mode_o    = mode_sel;
    n.mux_o     = mux_sel;
    n.edge_o    = edge_sel;
    n.mid_o     = loop_mid_strap;
    n.tcnt      = tdone ? 8'h00 : s.tcnt + 8'h01;
    unique case (s.st)
      lhp_pkg::H_IDLE: begin
        n.cs_n      = 1'b1;
        n.pa        = (s.mode_o == `LHP_MODE_ACK);
        n.pb        = 1'b1;
        n.pc        = (s.mode_o != `LHP_MODE_SER);
        n.bus_o     = (s.mode_o == `LHP_MODE_HW) ? loop_strap : 8'h00;
        n.bus_oe_n  = (s.mode_o != `LHP_MODE_HW) && (s.mode_o != `LHP_MODE_SER);
        n.cmd_ready = (s.mode_o != `LHP_MODE_HW);
        if (cmd_valid && s.cmd_ready) begin
          n.cmd_ready = 1'b0;
          n.rd        = ~cmd_write;
          n.addr_o    = cmd_addr;
          n.tcnt      = 8'h00;
          n.ph        = 1'b0;
          n.bcnt      = 5'h00;
          n.sreg      = {~cmd_write, 2'h0, cmd_addr, cmd_wdata};
          if (s.mode_o == `LHP_MODE_SER) begin
            n.st   = lhp_pkg::H_SHIFT;
            n.cs_n = 1'b0;
            n.pa   = 1'b0;
            n.pc   = n.sreg[15];
          end else begin
            n.st = lhp_pkg::H_ADDR;
            n.pb = (s.mode_o == `LHP_MODE_STB) ? 1'b1 : ~cmd_write;
            if (s.mux_o) begin
              n.bus_o    = {3'h0, cmd_addr};
              n.bus_oe_n = 1'b0;
              n.pa       = 1'b1;
            end
          end
        end
      end
      lhp_pkg::H_SHIFT: begin
        if (tdone) begin
          if (s.bcnt >= `LHP_CNT_CMD && s.bcnt != `LHP_CNT_END && s.ph != s.edge_o) begin
            n.rsh = {s.rsh[6:0], out_q};
          end
          if (!s.ph) begin
            if (s.bcnt == `LHP_CNT_END) begin
              n.cs_n      = 1'b1;
              n.st        = lhp_pkg::H_IDLE;
              n.rsp_valid = 1'b1;
              n.rsp_rdata = n.rsh;
            end else begin
              n.pa   = 1'b1;
              n.ph   = 1'b1;
              n.bcnt = s.bcnt + 5'h01;
            end
          end else begin
            n.pa   = 1'b0;
            n.ph   = 1'b0;
            n.sreg = {s.sreg[14:0], 1'b0};
            n.pc   = n.sreg[15];
          end
        end
      end
      lhp_pkg::H_ADDR: begin
        if (tdone) begin
          if (!s.ph) begin
            n.ph = 1'b1;
            n.pa = s.mux_o ? 1'b0 : s.pa;
          end else begin
            n.ph       = 1'b0;
            n.st       = lhp_pkg::H_STROBE;
            n.bus_o    = s.sreg[7:0];
            n.bus_oe_n = s.rd;
            if (s.mode_o == `LHP_MODE_STB && s.rd) begin
              n.pb = 1'b0;
            end else begin
              n.pc = 1'b0;
            end
          end
        end
      end
      lhp_pkg::H_STROBE: begin
        if (tdone) begin
          n.st = lhp_pkg::H_WAIT;
        end
      end
      lhp_pkg::H_WAIT: begin
        if ((s.mode_o == `LHP_MODE_STB) ? out_q : !out_q) begin
          n.st   = lhp_pkg::H_RELEASE;
          n.tcnt = 8'h00;
          n.pb   = (s.mode_o == `LHP_MODE_STB) ? 1'b1 : s.pb;
          n.pc   = 1'b1;
          if (s.rd) begin
            n.rsp_rdata = bus_q;
          end
        end
      end
      lhp_pkg::H_RELEASE: begin
        if (tdone) begin
          n.st        = lhp_pkg::H_IDLE;
          n.bus_oe_n  = 1'b1;
          n.rsp_valid = 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s          <= '0;
      s.st       <= lhp_pkg::H_IDLE;
      s.cs_n     <= 1'b1;
      s.pb       <= 1'b1;
      s.bus_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end
  // =====================================
  // outputs
  assign lnk.cs_n            = s.cs_n;
  assign lnk.pin_shift_clk   = s.pa;
  assign lnk.pin_rd_dir      = s.pb;
  assign lnk.pin_wr_strobe   = s.pc;
  assign lnk.mux_sel         = s.mux_o;
  assign lnk.edge_select     = s.edge_o;
  assign lnk.mode            = s.mode_o;
  assign lnk.addr            = s.addr_o;
  assign lnk.host_bus_o      = s.bus_o;
  assign lnk.host_bus_oe_n   = s.bus_oe_n;
  assign lnk.loop_select_mid = s.mid_o;
  assign cmd_ready           = s.cmd_ready;
  assign rsp_valid           = s.rsp_valid;
  assign rsp_rdata           = s.rsp_rdata;
endmodule // lhp_host

// ### verification/lhp_host_port_properties.sv
`include "lhp_consts.svh"
module lhp_host_port_properties (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       pin_shift_clk,
  input wire logic       pin_rd_dir,
  input wire logic       pin_wr_strobe,
  input wire logic       mux_sel,
  input wire logic       edge_select,
  input wire logic [1:0] mode,
  input wire logic       host_bus_oe_n,
  input wire logic       dev_bus_oe_n,
  input wire logic       dev_out,
  input wire logic       dev_out_oe_n,
  input wire logic [7:0] data_bus,
  input wire logic       pin_out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================
  // frame tracking: rising shift clock count and command byte
  logic       prev_sck;
  logic [4:0] cnt;
  logic [7:0] cmd;
  logic       ser;
  assign ser = (mode == `LHP_MODE_SER) && !cs_n;
  always_ff @(posedge clk_sys) begin
    prev_sck <= pin_shift_clk;
    if (rst || cs_n) begin
      cnt <= 5'h00;
      cmd <= 8'h00;
    end else if (pin_shift_clk && !prev_sck) begin
      if (cnt != 5'h1f) cnt <= cnt + 5'h01;
      if (cnt < 5'h08) cmd <= {cmd[6:0], pin_wr_strobe};
    end
  end
  // =====================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_ser_cmd_float: assert property (ser && cnt >= 5'h01 && cnt < 5'h08 |-> dev_out_oe_n)
    else $error("serial out driven during command byte");
  a_ser_write_low: assert property (ser && cnt >= 5'h09 && !cmd[`LHP_CMD_RD] |-> !dev_out_oe_n && !dev_out)
    else $error("serial out not low in write data byte");
  a_ser_read_drive: assert property (ser && cnt >= 5'h09 && cmd[`LHP_CMD_RD] |-> !dev_out_oe_n)
    else $error("serial out floating in read data byte");
  a_ser_launch_edge: assert property (ser && !dev_out_oe_n && $past(!dev_out_oe_n) && $changed(dev_out)
    |-> pin_shift_clk != edge_select)
    else $error("serial out launched on wrong edge");
  a_frame_length: assert property (!cs_n |-> cnt <= 5'h10)
    else $error("serial frame longer than sixteen cycles");
  a_ready_wait: assert property ((mode == `LHP_MODE_STB && !pin_rd_dir) [*8]
    |-> pin_out_ready == !dev_bus_oe_n)
    else $error("ready does not match read data presence");
  a_host_holds: assert property (mode == `LHP_MODE_STB && !pin_rd_dir && !pin_out_ready |=> !pin_rd_dir)
    else $error("host ended read while ready low");
  a_ack_read_data: assert property (mode == `LHP_MODE_ACK && pin_rd_dir && !pin_wr_strobe
    && !pin_out_ready |-> !dev_bus_oe_n)
    else $error("acknowledge without read data driven");
  a_no_contention: assert property (!(!dev_bus_oe_n && !host_bus_oe_n))
    else $error("both ends drive the shared bus");
  a_ale_addr: assert property (mode == `LHP_MODE_STB && mux_sel && pin_shift_clk |-> !host_bus_oe_n)
    else $error("address latch strobe without address on bus");
  a_ser_ground: assert property (mode == `LHP_MODE_SER && $past(mode) == `LHP_MODE_SER |-> data_bus == 8'h00)
    else $error("shared pins not grounded in serial mode");
endmodule // lhp_host_port_properties

// ### verification/lineif_host_port_pins_test.sv
`include "lhp_consts.svh"
module lineif_host_port_pins_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst;
  logic [3:0]  irq_src;
  logic [7:0]  rd_data, loop_strap, loop_mid_strap, cmd_wdata, rsp_rdata, reg_wdata, last_wd;
  logic        rd_valid, wr_req, rd_req, mux_sel, edge_sel, cmd_valid, cmd_write, cmd_ready, rsp_valid, irq_n;
  logic [4:0]  reg_addr, cmd_addr, last_wa;
  logic [15:0] loop_mode;
  logic [1:0]  mode_sel;
  logic [7:0]  dev_mem [32];
  logic [7:0]  exp_mem [32];
  int          rd_lat, rd_wait, err_count, n_compared;
  lhp_if lnk ();
  lhp_device i_lhp_device (.clk_sys, .rst, .lnk(lnk), .irq_src, .rd_data, .rd_valid, .reg_addr, .reg_wdata,
    .wr_req, .rd_req, .loop_mode);
  lhp_host #(.HALF(16)) i_lhp_host (.clk_sys, .rst, .lnk(lnk), .mode_sel, .mux_sel, .edge_sel, .loop_strap,
    .loop_mid_strap, .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata, .irq_n);
  lhp_host_port_properties i_lhp_host_port_properties (.clk_sys, .rst, .cs_n(lnk.cs_n),
    .pin_shift_clk(lnk.pin_shift_clk), .pin_rd_dir(lnk.pin_rd_dir), .pin_wr_strobe(lnk.pin_wr_strobe),
    .mux_sel(lnk.mux_sel),
    .edge_select(lnk.edge_select), .mode(lnk.mode), .host_bus_oe_n(lnk.host_bus_oe_n),
    .dev_bus_oe_n(lnk.dev_bus_oe_n), .dev_out(lnk.dev_out), .dev_out_oe_n(lnk.dev_out_oe_n),
    .data_bus(lnk.data_bus), .pin_out_ready(lnk.pin_out_ready));
  // =====================================
  // clock and register file behind the device
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    rd_valid <= 1'b0;
    if (wr_req === 1'b1) begin
      dev_mem[reg_addr] <= reg_wdata;
      last_wa <= reg_addr;
      last_wd <= reg_wdata;
    end
    if (rd_req === 1'b1) rd_wait <= rd_lat;
    else if (rd_wait == 1) begin
      rd_valid <= 1'b1;
      rd_data <= dev_mem[reg_addr];
      rd_wait <= 0;
    end else if (rd_wait > 1) rd_wait <= rd_wait - 1;
  end
  // =====================================
  // helpers
  function automatic logic [15:0] loop_expect(input logic [7:0] s, input logic [7:0] m);
    logic [15:0] e;
    e = 16'h0000;
    for (int i = 0; i < 8; i++) e[2*i +: 2] = m[i] ? `LHP_LOOP_NONE : (s[i] ? `LHP_LOOP_ANALOG : `LHP_LOOP_REMOTE);
    return e;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_cmd(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] r);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 2000) begin
      @(posedge clk_sys);
      k++;
    end
    check({15'h0000, cmd_ready}, 16'h0001);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr  <= a;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 4000) begin
      @(posedge clk_sys);
      k++;
    end
    r = rsp_rdata;
    check({15'h0000, rsp_valid}, 16'h0001);
  endtask
  task automatic run_mode(input logic [1:0] m, input logic mx, input logic eg);
    logic [4:0] a [4];
    logic [7:0] d [4];
    logic [7:0] r;
    mode_sel <= m;
    mux_sel  <= mx;
    edge_sel <= eg;
    repeat (30) @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      a[i] = (i == 0) ? 5'h1f : (i == 1) ? 5'h00 : 5'($urandom_range(1, 30));
      d[i] = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      rd_lat <= (m == `LHP_MODE_SER) ? 1 : 1 + $urandom_range(0, 7);
      do_cmd(1'b1, a[i], d[i], r);
      repeat (8) @(posedge clk_sys);
      check({3'h0, last_wa, last_wd}, {3'h0, a[i], d[i]});
      exp_mem[a[i]] = d[i];
    end
    for (int i = 3; i >= 0; i--) begin
      rd_lat <= (m == `LHP_MODE_SER) ? 1 : 1 + $urandom_range(0, 7);
      do_cmd(1'b0, a[i], 8'h00, r);
      check({8'h00, r}, {8'h00, exp_mem[a[i]]});
    end
    check(loop_mode, 16'h0000);
  endtask
  // =====================================
  // main sequence
  initial begin
    void'($urandom(32'hc8a7b370));
    err_count = 0;
    n_compared = 0;
    rd_wait = 0;
    rd_lat = 1;
    rst = 1'b1;
    irq_src = 4'h0;
    rd_data = 8'h00;
    rd_valid = 1'b0;
    mode_sel = `LHP_MODE_HW;
    mux_sel = 1'b0;
    edge_sel = 1'b0;
    loop_strap = 8'h00;
    loop_mid_strap = 8'h00;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 5'h00;
    cmd_wdata = 8'h00;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      loop_strap     <= (i == 0) ? 8'hff : (i < 3) ? 8'h00 : 8'($urandom);
      loop_mid_strap <= (i == 2) ? 8'hff : (i < 2) ? 8'h00 : 8'($urandom);
      repeat (12) @(posedge clk_sys);
      check(loop_mode, loop_expect(loop_strap, loop_mid_strap));
    end
    for (int i = 0; i < 4; i++) begin
      irq_src <= 4'h1 << i;
      repeat (10) @(posedge clk_sys);
      check({15'h0000, irq_n}, 16'h0000);
      irq_src <= 4'h0;
      repeat (10) @(posedge clk_sys);
      check({15'h0000, irq_n}, 16'h0001);
    end
    run_mode(`LHP_MODE_SER, 1'b0, 1'b0);
    run_mode(`LHP_MODE_SER, 1'b0, 1'b1);
    run_mode(`LHP_MODE_STB, 1'b0, 1'b0);
    run_mode(`LHP_MODE_STB, 1'b1, 1'b0);
    run_mode(`LHP_MODE_ACK, 1'b0, 1'b0);
    run_mode(`LHP_MODE_ACK, 1'b1, 1'b0);
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    summarize();
  end
endmodule // lineif_host_port_pins_test
